/* File: rtl/audio_port_pkg.sv */
// Constants, register map and carrier types for the audio port slot and clock block.
// Assumes a single 200 MHz system clock and an 8-bit register port.
package audio_port_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_SECOND_SLOT = 8'h0C;
  localparam logic [7:0] ADDR_THIRD_SLOT  = 8'h0D;
  localparam logic [7:0] ADDR_FOURTH_SLOT = 8'h0E;
  localparam logic [7:0] ADDR_MASTER_CFG = 8'h13;
  localparam logic [7:0] ADDR_FORMAT_CFG = 8'h20;
  localparam logic [7:0] ADDR_STATUS     = 8'h21;

  // Values after reset
  localparam logic [5:0] RST_SECOND_SLOT = 6'h01;
  localparam logic [5:0] RST_THIRD_SLOT  = 6'h02;
  localparam logic [5:0] RST_FOURTH_SLOT = 6'h03;
  localparam logic [7:0] RST_MASTER_CFG = 8'h02;
  localparam logic [2:0] RST_FORMAT_CFG = 3'h0;

  // Master configuration field positions, plus the code mode bit of the format register
  localparam int POS_ROLE      = 7;
  localparam int POS_AUTO_OFF  = 6;
  localparam int POS_PLL_BYP   = 5;
  localparam int POS_GATE      = 4;
  localparam int POS_FAMILY    = 3;
  localparam int POS_FREQ_HI   = 2;
  localparam int POS_CODE_MODE = 2;

  // Frame format codes
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LEFT_JUSTIFIED = 2'h2;

  // Frame geometry: 64 slots of 16 bits
  localparam int                SLOT_BITS  = 16;
  localparam logic [9:0]        FRAME_LAST = 10'h3FF;
  localparam int                HALF_BIT   = 9;

  // Bit clock half period in system cycles for each rate family
  localparam logic [2:0] HALF_CYC_48 = 3'h4;
  localparam logic [2:0] HALF_CYC_44 = 3'h5;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // One frame of channel samples
  typedef struct packed {
    logic [SLOT_BITS-1:0] ch2;
    logic [SLOT_BITS-1:0] ch3;
    logic [SLOT_BITS-1:0] ch4;
  } frame_t;

endpackage : audio_port_pkg

/* File: rtl/audio_port_slot_and_clock_cfg.sv */
// Slot placement and clock role logic of the audio serial port, with its registers.
// Assumes a register master on clk_sys and bit clock / frame sync pins from the far end.
`timescale 1ns/1ps
module audio_port_slot_and_clock_cfg (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // Register port
  input  wire audio_port_pkg::reg_req_t req,
  output logic [7:0]                    rdata,
  // Sample frames in
  input  wire logic                     frame_valid,
  output logic                          frame_ready,
  input  wire audio_port_pkg::frame_t   frame_data,
  // Bit clock pin
  input  wire logic                     bclk_in,
  output logic                          bclk_out,
  output logic                          bclk_oe,
  // Frame sync pin
  input  wire logic                     frame_sync_line_in,
  output logic                          frame_sync_line_out,
  output logic                          frame_sync_line_oe,
  // Serial data pin
  output logic                          sdout,
  output logic                          sdout_oe,
  // Clock tree controls
  output logic                          pll_enable,
  output logic                          auto_divider_en,
  output logic                          rate_family_select,
  output logic [2:0]                    master_clock_freq_code,
  output logic                          master_clock_code_valid
);
  import audio_port_pkg::*;

  // Configuration registers
  logic [5:0] second_channel_slot_r;
  logic [5:0] third_channel_slot_r;
  logic [5:0] fourth_channel_slot_r;
  logic [7:0] port_master_clock_cfg_r;
  logic [2:0] format_cfg_r;
  logic [7:0] rdata_r;

  // Decoded controls
  logic       port_role_select;
  logic       port_clock_gate;
  logic       auto_pll_bypass;
  logic       auto_off;
  logic       master_clock_code_mode;
  logic [1:0] frame_format;
  logic       is_i2s;

  // Pin synchronisers and line edges
  logic       bclk_s1_r;
  logic       bclk_s2_r;
  logic       fs_s1_r;
  logic       fs_s2_r;
  logic       line_bclk;
  logic       line_fs;
  logic       line_bclk_q_r;
  logic       fs_q_r;
  logic       rise;
  logic       fall;
  logic       start;

  // Clock generator
  logic [2:0] div_cnt_r;
  logic [2:0] half_cyc;
  logic       bclk_gen_r;
  logic       fs_gen_r;
  logic [9:0] gen_cnt_r;
  logic [9:0] gen_cnt_nxt;
  logic       bclk_pin_r;
  logic       fs_pin_r;

  // Frame position and output
  logic [9:0] pos_r;
  logic       pre_r;
  logic       active_r;
  frame_t     frame_r;
  frame_t     buf_data;
  logic       buf_valid;
  logic       hit;
  logic [SLOT_BITS-1:0] word;
  logic       sdout_r;
  logic       sdout_oe_r;

  assign port_role_select       = port_master_clock_cfg_r[POS_ROLE];
  assign auto_off               = port_master_clock_cfg_r[POS_AUTO_OFF];
  assign auto_pll_bypass        = port_master_clock_cfg_r[POS_PLL_BYP];
  assign port_clock_gate        = port_master_clock_cfg_r[POS_GATE];
  assign rate_family_select     = port_master_clock_cfg_r[POS_FAMILY];
  assign master_clock_freq_code = port_master_clock_cfg_r[POS_FREQ_HI:0];
  assign master_clock_code_mode = format_cfg_r[POS_CODE_MODE];
  assign frame_format           = format_cfg_r[1:0];
  assign is_i2s                 = (frame_format == FMT_I2S);

  assign auto_divider_en = !auto_off;
  assign pll_enable = !auto_off && !auto_pll_bypass;
  // frequency code valid in master mode while the format code mode bit is clear
  assign master_clock_code_valid = port_role_select && !master_clock_code_mode;

  // Register writes; reserved slot bits are never stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      second_channel_slot_r   <= RST_SECOND_SLOT;
      third_channel_slot_r    <= RST_THIRD_SLOT;
      fourth_channel_slot_r   <= RST_FOURTH_SLOT;
      port_master_clock_cfg_r <= RST_MASTER_CFG;
      format_cfg_r            <= RST_FORMAT_CFG;
    end else if (req.wr) begin
      unique case (req.addr)
        ADDR_SECOND_SLOT: second_channel_slot_r  <= req.wdata[5:0];
        ADDR_THIRD_SLOT:  third_channel_slot_r   <= req.wdata[5:0];
        ADDR_FOURTH_SLOT: fourth_channel_slot_r  <= req.wdata[5:0];
        ADDR_MASTER_CFG: port_master_clock_cfg_r <= req.wdata;
        ADDR_FORMAT_CFG: format_cfg_r            <= req.wdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_SECOND_SLOT: rdata_r <= {2'h0, second_channel_slot_r};
        ADDR_THIRD_SLOT:  rdata_r <= {2'h0, third_channel_slot_r};
        ADDR_FOURTH_SLOT: rdata_r <= {2'h0, fourth_channel_slot_r};
        ADDR_MASTER_CFG: rdata_r <= port_master_clock_cfg_r;
        ADDR_FORMAT_CFG: rdata_r <= {5'h00, format_cfg_r};
        ADDR_STATUS:     rdata_r <= {4'h0, buf_valid, active_r, auto_divider_en, pll_enable};
        default:         rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  // Two-stage synchronisers on the incoming clock pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      fs_s1_r   <= 1'b0;
      fs_s2_r   <= 1'b0;
    end else begin
      bclk_s1_r <= bclk_in;
      bclk_s2_r <= bclk_s1_r;
      fs_s1_r   <= frame_sync_line_in;
      fs_s2_r   <= fs_s1_r;
    end
  end

  // bit clock rate follows the family
  assign half_cyc    = rate_family_select ? HALF_CYC_44 : HALF_CYC_48;
  assign gen_cnt_nxt = gen_cnt_r + 10'h001;

  // Bit clock and frame sync generator for master mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt_r  <= 3'h0;
      bclk_gen_r <= 1'b0;
      fs_gen_r   <= 1'b0;
      gen_cnt_r  <= 10'h000;
    end else if (!port_role_select) begin
      div_cnt_r  <= 3'h0;
      bclk_gen_r <= 1'b0;
      fs_gen_r   <= 1'b0;
      gen_cnt_r  <= 10'h000;
    end else if (div_cnt_r == half_cyc - 3'h1) begin
      div_cnt_r  <= 3'h0;
      bclk_gen_r <= ~bclk_gen_r;
      if (bclk_gen_r) begin
        // Falling edge: advance and shape the frame sync
        gen_cnt_r <= gen_cnt_nxt;
        unique case (frame_format)
          FMT_TDM: fs_gen_r <= (gen_cnt_nxt == FRAME_LAST);
          FMT_I2S: fs_gen_r <= gen_cnt_nxt[HALF_BIT];
          default: fs_gen_r <= !gen_cnt_nxt[HALF_BIT];
        endcase
      end
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // pin drive: outputs only in master mode, gated on request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bclk_pin_r <= 1'b0;
      fs_pin_r   <= 1'b0;
    end else begin
      bclk_pin_r <= bclk_gen_r && !port_clock_gate;
      fs_pin_r   <= fs_gen_r && !port_clock_gate;
    end
  end
  assign bclk_out            = bclk_pin_r;
  assign frame_sync_line_out = fs_pin_r;
  assign bclk_oe             = port_role_select;
  assign frame_sync_line_oe  = port_role_select;

  // line source: own generator or the far end's clocks
  assign line_bclk = port_role_select ? bclk_gen_r : bclk_s2_r;
  assign line_fs   = port_role_select ? fs_gen_r : fs_s2_r;
  assign rise      = line_bclk && !line_bclk_q_r;
  assign fall      = !line_bclk && line_bclk_q_r;
  assign start     = rise && (is_i2s ? (fs_q_r && !line_fs) : (!fs_q_r && line_fs));

  // Edge history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_bclk_q_r <= 1'b0;
      fs_q_r        <= 1'b0;
    end else begin
      line_bclk_q_r <= line_bclk;
      if (rise) fs_q_r <= line_fs;
    end
  end

  // Frame position; I2S adds one idle bit after the frame edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_r    <= 10'h000;
      pre_r    <= 1'b0;
      active_r <= 1'b0;
      frame_r  <= '0;
    end else if (start) begin
      pos_r    <= 10'h000;
      pre_r    <= is_i2s;
      active_r <= 1'b1;
      frame_r  <= buf_valid ? buf_data : '0;
    end else if (rise) begin
      if (pre_r) pre_r <= 1'b0;
      else pos_r <= pos_r + 10'h001;
    end
  end

  // One frame is taken from the buffer per frame edge
  frame_buffer u_frame_buffer (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (frame_valid),
    .in_ready  (frame_ready),
    .in_data   (frame_data),
    .out_valid (buf_valid),
    .out_ready (start),
    .out_data  (buf_data)
  );

  always_comb begin
    hit   = 1'b1;
    word  = frame_r.ch2;
    if (second_channel_slot_r == pos_r[9:4]) begin
      word  = frame_r.ch2;
    end else if (third_channel_slot_r == pos_r[9:4]) begin
      word  = frame_r.ch3;
    end else if (fourth_channel_slot_r == pos_r[9:4]) begin
      word  = frame_r.ch4;
    end else begin
      hit = 1'b0;
    end
  end

  // Serial data changes on the falling bit clock edge, MSB first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdout_r    <= 1'b0;
      sdout_oe_r <= 1'b0;
    end else if (fall) begin
      sdout_oe_r <= active_r && !pre_r && hit;
      sdout_r    <= (active_r && !pre_r && hit) ? word[~pos_r[3:0]] : 1'b0;
    end
  end
  assign sdout    = sdout_r;
  assign sdout_oe = sdout_oe_r;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_write_master(logic [7:0] v);
    req.wr && req.addr == ADDR_MASTER_CFG && req.wdata == v;
  endsequence

  a_reserved_read_zero:
    assert property (req.rd && (req.addr == ADDR_THIRD_SLOT || req.addr == ADDR_FOURTH_SLOT)
                     |=> rdata[7:6] == 2'h0)
    else $error("reserved slot bits read nonzero");
  a_ch3_reset_slot:
    assert property ($fell(rst) |-> third_channel_slot_r == 6'h02)
    else $error("channel three slot reset wrong");
  a_ch4_reset_slot:
    assert property ($fell(rst) |-> fourth_channel_slot_r == 6'h03)
    else $error("channel four slot reset wrong");
  a_master_cfg_reset:
    assert property ($fell(rst) |-> rdata == 8'h00 && !bclk_oe && pll_enable
                     && master_clock_freq_code == 3'h2)
    else $error("master configuration reset wrong");
  a_role_drives_pins:
    assert property (s_write_master(8'h80) |=> bclk_oe && frame_sync_line_oe ##1 bclk_oe)
    else $error("master role does not drive pins");
  a_auto_clock_off:
    assert property (s_write_master(8'h40) |=> !auto_divider_en && !pll_enable)
    else $error("auto clock not disabled");
  a_pll_bypass_auto:
    assert property (s_write_master(8'h20) |=> auto_divider_en && !pll_enable)
    else $error("PLL not bypassed");
  a_gate_holds_low:
    assert property ((port_role_select && port_clock_gate)[*2] |-> !bclk_out && !frame_sync_line_out)
    else $error("gated clocks toggled");
  a_family_half_44:
    assert property (disable iff (rst || !rate_family_select || !port_role_select)
                     port_role_select && rate_family_select && $rose(bclk_gen_r)
                     |-> bclk_gen_r[*5] ##1 !bclk_gen_r)
    else $error("44.1 kHz family half period wrong");
  a_freq_code_valid:
    assert property (s_write_master(8'h85) ##0 !master_clock_code_mode
                     |=> master_clock_code_valid && master_clock_freq_code == 3'h5)
    else $error("frequency code not valid in master mode");
  a_slot_owner_prio:
    assert property (fall && active_r && !pre_r && second_channel_slot_r == pos_r[9:4]
                     |=> sdout_oe && sdout == frame_r.ch2[~pos_r[3:0]])
    else $error("channel two lost its slot");
  a_slot_code_match:
    assert property (fall && !hit |=> !sdout_oe)
    else $error("data driven outside own slot");

endmodule : audio_port_slot_and_clock_cfg

/* File: rtl/frame_buffer.sv */
// Two-entry buffer of sample frames between the source and the serial port.
// Assumes push and pop happen on clk_sys; either side may stall.
`timescale 1ns/1ps
module frame_buffer (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Filling side
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire audio_port_pkg::frame_t in_data,
  // Draining side
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output audio_port_pkg::frame_t    out_data
);
  import audio_port_pkg::*;

  frame_t     mem_r [2];
  logic       wr_ptr_r;
  logic       rd_ptr_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  // Handshakes
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop) cnt_r <= cnt_r + 2'h1;
      else if (pop && !push) cnt_r <= cnt_r - 2'h1;
    end
  end

endmodule : frame_buffer

/* File: test/audio_port_slot_and_clock_cfg_tb.sv */
// Self-checking bench for the audio port slot and clock configuration block.
// Assumes dsp_port_model sources the bit clock and frame sync in slave mode.
`timescale 1ns/1ps
module audio_port_slot_and_clock_cfg_tb;
  import audio_port_pkg::*;
  logic          clk_sys, rst, frame_valid, frame_ready, run, bo_q, fmt_i2s;
  logic          bclk_out, bclk_oe, fs_out, fs_oe, sdout, sdout_oe;
  logic          pll_en, auto_en, family, code_ok, pm_bclk, pm_fs;
  logic [2:0]    fcode;
  logic [7:0]    rdata;
  reg_req_t      req;
  frame_t        frame_data;
  logic [1023:0] pm_cap, pm_own;
  int            pm_frames, bad_count = 0, total_checks = 0, bo_rises = 0, cap_off = 0;
  wire           bclk_w = bclk_oe ? bclk_out : pm_bclk;
  wire           fs_w = fs_oe ? fs_out : pm_fs;

  audio_port_slot_and_clock_cfg audio_port_slot_and_clock_cfg_inst (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
    .bclk_in(bclk_w), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
    .frame_sync_line_in(fs_w), .frame_sync_line_out(fs_out), .frame_sync_line_oe(fs_oe),
    .sdout(sdout), .sdout_oe(sdout_oe), .pll_enable(pll_en), .auto_divider_en(auto_en),
    .rate_family_select(family), .master_clock_freq_code(fcode),
    .master_clock_code_valid(code_ok));

  dsp_port_model dsp_port_model_inst (
    .run(run), .i2s(fmt_i2s), .bclk(pm_bclk), .frame_sync(pm_fs),
    .sdata(sdout), .sdata_oe(sdout_oe),
    .cap(pm_cap), .own(pm_own), .frames(pm_frames));

  // Clock of 5 ns
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Count rising edges of the driven bit clock
  always @(posedge clk_sys) begin
    bo_q <= bclk_out;
    if (bclk_out && !bo_q) bo_rises <= bo_rises + 1;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask : rd_chk

  task automatic count_rises(output int n);
    int s;
    s = bo_rises;
    repeat (160) @(posedge clk_sys);
    n = bo_rises - s;
  endtask : count_rises

  task automatic wait_frames(input int n);
    int t;
    t = pm_frames + n;
    for (int i = 0; i < 15000 * n && pm_frames < t; i++) @(posedge clk_sys);
    if (pm_frames < t) begin
      bad_count++;
      stop_test();
    end
  endtask : wait_frames

  // Compare one 16-bit slot of the captured frame, MSB first
  task automatic chk_slot(input int s, input logic o, input logic [15:0] d);
    logic [15:0] w;
    logic [15:0] m;
    for (int b = 0; b < 16; b++) begin
      w[15-b] = pm_cap[s*16+b+cap_off];
      m[15-b] = pm_own[s*16+b+cap_off];
    end
    chk("slot owner", {16{o}}, m);
    if (o) chk("slot data", d, w);
  endtask : chk_slot

  task automatic check_reset;
    rd_chk("second_channel_slot", ADDR_SECOND_SLOT, 8'h01);
    rd_chk("third_channel_slot", ADDR_THIRD_SLOT, 8'h02);
    rd_chk("fourth_channel_slot", ADDR_FOURTH_SLOT, 8'h03);
    rd_chk("master cfg", ADDR_MASTER_CFG, 8'h02);
    chk("reset outs", {bclk_oe, fs_oe, pll_en, auto_en, family, fcode, code_ok}, 9'h064);
  endtask : check_reset

  task automatic check_slot_regs;
    wr(ADDR_THIRD_SLOT, 8'h3F);
    rd_chk("ch3 upper", ADDR_THIRD_SLOT, 8'h3F);
    wr(ADDR_FOURTH_SLOT, 8'h20);
    rd_chk("ch4 upper", ADDR_FOURTH_SLOT, 8'h20);
    wr(8'h7F, 8'hAA);
    rd_chk("unmapped", 8'h7F, 8'h00);
    wr(ADDR_THIRD_SLOT, 8'h02);
    wr(ADDR_FOURTH_SLOT, 8'h03);
  endtask : check_slot_regs

  task automatic check_master_cfg;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_MASTER_CFG, 8'h80 | 8'(c));
      chk("master code", {bclk_oe, fs_oe, fcode, code_ok}, {2'h3, 3'(c), 1'b1});
    end
    wr(ADDR_MASTER_CFG, 8'h40);
    chk("auto off", {pll_en, auto_en}, 2'h0);
    wr(ADDR_MASTER_CFG, 8'h20);
    chk("pll bypass", {pll_en, auto_en}, 2'h1);
    wr(ADDR_MASTER_CFG, 8'h08);
    chk("family slave", {family, bclk_oe, fs_oe, code_ok}, 4'h8);
    wr(ADDR_FORMAT_CFG, 8'h04);
    wr(ADDR_MASTER_CFG, 8'h82);
    chk("code mode", code_ok, 1'b0);
    wr(ADDR_FORMAT_CFG, 8'h00);
  endtask : check_master_cfg

  task automatic check_gate;
    int n;
    wr(ADDR_MASTER_CFG, 8'h80);
    count_rises(n);
    chk("bclk 48k", 1'b1, n >= 19 && n <= 21);
    wr(ADDR_MASTER_CFG, 8'h88);
    count_rises(n);
    chk("bclk 44k", 1'b1, n >= 15 && n <= 17);
    wr(ADDR_MASTER_CFG, 8'h90);
    // Let the last ungated pin value drain before counting
    repeat (2) @(posedge clk_sys);
    count_rises(n);
    chk("gated bclk", 16'h0000, 16'(n));
    chk("gated sync", 1'b0, fs_out);
    wr(ADDR_MASTER_CFG, 8'h02);
  endtask : check_gate

  task automatic check_tdm_slots;
    chk("buffer empty", 1'b1, frame_ready);
    @(posedge clk_sys);
    frame_valid <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("buffer full", 1'b0, frame_ready);
    run <= 1'b1;
    wait_frames(2);
    chk_slot(0, 1'b0, 16'h0000);
    chk_slot(1, 1'b1, 16'hA5C3);
    chk_slot(2, 1'b1, 16'h1234);
    chk_slot(3, 1'b1, 16'h0F0F);
  endtask : check_tdm_slots

  task automatic check_conflict;
    wr(ADDR_THIRD_SLOT, 8'h22);
    wr(ADDR_FOURTH_SLOT, 8'h01);
    wait_frames(2);
    chk_slot(1, 1'b1, 16'hA5C3);
    chk_slot(3, 1'b0, 16'h0000);
    chk_slot(2, 1'b0, 16'h0000);
    chk_slot(34, 1'b1, 16'h1234);
  endtask : check_conflict

  // I2S: one idle bit after the sync fall shifts every captured bit by one
  task automatic check_i2s_slots;
    @(posedge clk_sys);
    fmt_i2s <= 1'b1;
    wr(ADDR_FORMAT_CFG, {6'h00, FMT_I2S});
    wait_frames(2);
    cap_off = 1;
    chk_slot(1, 1'b1, 16'hA5C3);
    chk_slot(34, 1'b1, 16'h1234);
    chk_slot(2, 1'b0, 16'h0000);
    chk_slot(3, 1'b0, 16'h0000);
    run <= 1'b0;
  endtask : check_i2s_slots

  // Main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    run = 1'b0;
    fmt_i2s = 1'b0;
    frame_valid = 1'b0;
    frame_data = {16'hA5C3, 16'h1234, 16'h0F0F};
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    check_reset();
    check_slot_regs();
    check_master_cfg();
    check_gate();
    check_tdm_slots();
    check_conflict();
    check_i2s_slots();
    stop_test();
  end

  // Watchdog against a hung run
  initial begin
    #450000;
    bad_count++;
    stop_test();
  end
endmodule : audio_port_slot_and_clock_cfg_tb

/* File: test/dsp_port_model.sv */
// Behavioural far-end audio port that sources slave clocks and captures data.
// Assumes TDM or I2S framing of 1024 bits; the data pin is sampled on rising edges.
`timescale 1ns/1ps
module dsp_port_model #(
  parameter real HALF_NS = 30.3
) (
  // Control
  input  wire logic          run,
  input  wire logic          i2s,
  // Port pins
  output logic               bclk,
  output logic               frame_sync,
  input  wire logic          sdata,
  input  wire logic          sdata_oe,
  // Captured frame
  output logic [1023:0]      cap,
  output logic [1023:0]      own,
  output int                 frames
);
  initial begin
    bclk = 1'b0;
    frame_sync = 1'b0;
    frames = 0;
  end

  // far end drives both clock lines for a slave device
  always begin
    wait (run);
    for (int k = 0; k < 1024; k++) begin
      // I2S holds sync low for the first half, so the frame starts at its fall
      frame_sync = i2s ? (k >= 512) : (k == 0);
      #(HALF_NS) bclk = 1'b1;
      if (k > 0) begin
        cap[k-1] = sdata;
        own[k-1] = sdata_oe;
      end
      #(HALF_NS) bclk = 1'b0;
    end
    frames = frames + 1;
  end
endmodule : dsp_port_model
